/* File: logic/cfgh_pkg.sv */
// Package with offsets, layouts and reset values of the configuration header registers.
package cfgh_pkg;
  // Printed byte offsets in configuration space.
  localparam logic [7:0] CFGH_OFF_REVISION = 8'h08;
  localparam logic [7:0] CFGH_OFF_MEM_BASE = 8'h14;
  localparam logic [7:0] CFGH_OFF_BOARD_VARIANT = 8'h2E;
  localparam logic [7:0] CFGH_OFF_BURST_NEED = 8'h3E;
  localparam logic [7:0] CFGH_OFF_ACCESS_INTERVAL = 8'h3F;
  // Dword index of each register, as carried on the configuration port.
  localparam logic [5:0] CFGH_DW_REVISION = CFGH_OFF_REVISION[7:2];
  localparam logic [5:0] CFGH_DW_MEM_BASE = CFGH_OFF_MEM_BASE[7:2];
  localparam logic [5:0] CFGH_DW_BOARD_VARIANT = CFGH_OFF_BOARD_VARIANT[7:2];
  localparam logic [5:0] CFGH_DW_LATENCY = CFGH_OFF_BURST_NEED[7:2];
  // Field positions inside the memory window base register.
  localparam int CFGH_MEM_IND_BIT = 0;
  localparam int CFGH_MEM_MAP_LO_BIT = 1;
  localparam int CFGH_MEM_MAP_HI_BIT = 2;
  localparam int CFGH_MEM_RSVD_LO = 3;
  localparam int CFGH_MEM_RSVD_HI = 6;
  localparam int CFGH_MEM_BASE_LO = 7;
  localparam int CFGH_MEM_BASE_W = 25;
  // EEPROM word addresses and fields of the configuration words.
  localparam logic [5:0] CFGH_EE_BOARD_VARIANT_WORD = 6'h03;
  localparam logic [5:0] CFGH_EE_CONFIG_WORD = 6'h04;
  localparam logic [5:0] CFGH_EE_LATENCY_WORD = 6'h05;
  localparam int CFGH_EE_LOW_MEG_BIT = 0;
  localparam int CFGH_EE_ACCESS_LO = 0;
  localparam int CFGH_EE_BURST_LO = 8;
  // Time unit of both latency bytes and the expected figures.
  localparam int CFGH_INTERVAL_UNIT_NS = 250;
  localparam int CFGH_ACCESS_INTERVAL_NS = 2500;
  localparam int CFGH_BURST_PERIOD_NS = 2500;
  localparam logic [7:0] CFGH_RST_ACCESS_INTERVAL = 8'(CFGH_ACCESS_INTERVAL_NS / CFGH_INTERVAL_UNIT_NS);
  localparam logic [7:0] CFGH_RST_BURST_NEED = 8'(CFGH_BURST_PERIOD_NS / CFGH_INTERVAL_UNIT_NS);
  localparam logic [15:0] CFGH_RST_BOARD_VARIANT = 16'h0000;
  localparam logic [24:0] CFGH_RST_MEM_BASE = 25'h0000000;
  localparam logic CFGH_RST_LOW_MEG = 1'b0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] dword;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfgh_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfgh_rsp_t;
endpackage

/* File: logic/cfgh_regs.sv */
// Configuration header registers: revision, memory window base, board variant and latency bytes.
// Functional notes
// - Bus access interval byte reports needed mastership frequency in 250 ns units.
// - Bus access interval byte comes from the low byte of the EEPROM latency word (word five).
// - Expected bus access interval is 10, meaning 2.5 us.
// - A 32-bit host-writable memory window base register sits at 0x14.
// - Bit 0 of the memory window base always reads one.
// - Bits 2 and 1 read-only; bit 2 zero, bit 1 is the low megabyte flag.
// - Map value 01 asks for below one megabyte, 00 anywhere.
// - Bits 6 to 3 of the memory window base read zero.
// - Upper 25 bits hold the host-written base of a 128-byte window.
// - Burst length byte reports needed burst period in 250 ns units from EEPROM.
// - Expected burst length value is 10 on a 33 MHz bus.
// - An 8-bit read-only silicon revision code is readable.
// - Board variant identifier is loaded from EEPROM word three after reset.
`timescale 1ns/1ps
module cfgh_regs #(
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h5A // Arbitrary value.
) (
  input wire logic clk, // 100 MHz clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire cfgh_pkg::cfgh_req_t cfg_req, // Configuration access from the bus unit.
  output cfgh_pkg::cfgh_rsp_t cfg_rsp, // Registered answer, ack one cycle after the request.
  input wire logic ee_valid, // One-cycle strobe of a word fetched from EEPROM.
  input wire logic [5:0] ee_addr, // EEPROM word address of the fetched word.
  input wire logic [15:0] ee_data // EEPROM word contents.
);
  import cfgh_pkg::*;

  logic [24:0] window_base_ff, nxt_window_base;
  logic low_megabyte_flag_ff, nxt_low_megabyte_flag;
  logic [7:0] bus_access_interval_ff, nxt_bus_access_interval;
  logic [7:0] burst_length_need_ff, nxt_burst_length_need;
  logic [15:0] board_variant_code_ff, nxt_board_variant_code;
  cfgh_rsp_t rsp_ff, nxt_rsp;
  logic [31:0] mem_base_word;
  logic [31:0] read_word;
  logic do_write;
  logic [24:0] base_mask;

  assign cfg_rsp = rsp_ff;
  assign do_write = cfg_req.valid && cfg_req.write;
  assign base_mask = {{8{cfg_req.byte_en[3]}}, {8{cfg_req.byte_en[2]}}, {8{cfg_req.byte_en[1]}},
                      cfg_req.byte_en[0]};

  // Read view of the window base: indicator, map type, reserved zeros, base.
  always_comb begin
    mem_base_word = 32'h00000000;
    mem_base_word[CFGH_MEM_IND_BIT] = 1'b1;
    mem_base_word[CFGH_MEM_MAP_LO_BIT] = low_megabyte_flag_ff;
    mem_base_word[CFGH_MEM_MAP_HI_BIT] = 1'b0;
    mem_base_word[CFGH_MEM_RSVD_HI:CFGH_MEM_RSVD_LO] = 4'h0;
    mem_base_word[31:CFGH_MEM_BASE_LO] = window_base_ff;
  end

  // Read multiplexer; unknown dwords read as zero.
  always_comb begin
    read_word = 32'h00000000;
    case (cfg_req.dword)
      CFGH_DW_REVISION: begin
        read_word[7:0] = SILICON_REVISION_CODE;
      end
      CFGH_DW_MEM_BASE: begin
        read_word = mem_base_word;
      end
      CFGH_DW_BOARD_VARIANT: begin
        read_word[31:16] = board_variant_code_ff;
      end
      CFGH_DW_LATENCY: begin
        read_word[31:24] = bus_access_interval_ff;
        read_word[23:16] = burst_length_need_ff;
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  always_comb begin
    nxt_rsp.ack = cfg_req.valid;
    nxt_rsp.rdata = (cfg_req.valid && !cfg_req.write) ? read_word : 32'h00000000;
    nxt_window_base = window_base_ff;
    // Only the base field takes writes; the low seven bits are never stored.
    if (do_write && cfg_req.dword == CFGH_DW_MEM_BASE) begin
      nxt_window_base = (window_base_ff & ~base_mask) | (cfg_req.wdata[31:CFGH_MEM_BASE_LO] & base_mask);
    end
    nxt_low_megabyte_flag = low_megabyte_flag_ff;
    nxt_bus_access_interval = bus_access_interval_ff;
    nxt_burst_length_need = burst_length_need_ff;
    nxt_board_variant_code = board_variant_code_ff;
    // Read-only values change only when the EEPROM reader hands over a word.
    if (ee_valid) begin
      case (ee_addr)
        CFGH_EE_BOARD_VARIANT_WORD: begin
          nxt_board_variant_code = ee_data;
        end
        CFGH_EE_CONFIG_WORD: begin
          nxt_low_megabyte_flag = ee_data[CFGH_EE_LOW_MEG_BIT];
        end
        CFGH_EE_LATENCY_WORD: begin
          nxt_bus_access_interval = ee_data[CFGH_EE_ACCESS_LO +: 8];
          nxt_burst_length_need = ee_data[CFGH_EE_BURST_LO +: 8];
        end
        default: begin
          nxt_board_variant_code = board_variant_code_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      window_base_ff <= CFGH_RST_MEM_BASE;
      low_megabyte_flag_ff <= CFGH_RST_LOW_MEG;
      bus_access_interval_ff <= CFGH_RST_ACCESS_INTERVAL;
      burst_length_need_ff <= CFGH_RST_BURST_NEED;
      board_variant_code_ff <= CFGH_RST_BOARD_VARIANT;
      rsp_ff <= '0;
    end else begin
      window_base_ff <= nxt_window_base;
      low_megabyte_flag_ff <= nxt_low_megabyte_flag;
      bus_access_interval_ff <= nxt_bus_access_interval;
      burst_length_need_ff <= nxt_burst_length_need;
      board_variant_code_ff <= nxt_board_variant_code;
      rsp_ff <= nxt_rsp;
    end
  end

  property p_ack_follows;
    @(posedge clk) disable iff (!reset_n) cfg_req.valid |=> cfg_rsp.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("Ack missing after request.");

  property p_rev_read;
    @(posedge clk) disable iff (!reset_n)
      cfg_req.valid && !cfg_req.write && cfg_req.dword == CFGH_DW_REVISION
      |=> cfg_rsp.rdata[7:0] == SILICON_REVISION_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("Revision code read wrong.");

  property p_ind_bit;
    @(posedge clk) disable iff (!reset_n)
      cfg_req.valid && !cfg_req.write && cfg_req.dword == CFGH_DW_MEM_BASE |=> cfg_rsp.rdata[0];
  endproperty
  a_ind_bit: assert property (p_ind_bit) else $error("Memory indicator bit not one.");

  property p_map_type;
    @(posedge clk) disable iff (!reset_n)
      cfg_req.valid && !cfg_req.write && cfg_req.dword == CFGH_DW_MEM_BASE
      |=> cfg_rsp.rdata[2:1] == {1'b0, $past(low_megabyte_flag_ff)};
  endproperty
  a_map_type: assert property (p_map_type) else $error("Map type field wrong.");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!reset_n)
      cfg_rsp.ack |-> cfg_rsp.rdata[6:3] == 4'h0 || $past(cfg_req.dword) != CFGH_DW_MEM_BASE;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero.");

  property p_base_write;
    @(posedge clk) disable iff (!reset_n)
      do_write && cfg_req.dword == CFGH_DW_MEM_BASE && cfg_req.byte_en == 4'hF
      ##1 cfg_req.valid && !cfg_req.write && cfg_req.dword == CFGH_DW_MEM_BASE
      |=> cfg_rsp.rdata[31:7] == $past(cfg_req.wdata[31:7], 2);
  endproperty
  a_base_write: assert property (p_base_write) else $error("Window base not stored.");

  property p_board_load;
    @(posedge clk) disable iff (!reset_n)
      ee_valid && ee_addr == CFGH_EE_BOARD_VARIANT_WORD |=> board_variant_code_ff == $past(ee_data);
  endproperty
  a_board_load: assert property (p_board_load) else $error("Board variant not loaded.");

  property p_latency_load;
    @(posedge clk) disable iff (!reset_n)
      ee_valid && ee_addr == CFGH_EE_LATENCY_WORD
      ##1 cfg_req.valid && !cfg_req.write && cfg_req.dword == CFGH_DW_LATENCY
      |=> cfg_rsp.rdata[31:16] == {$past(ee_data[7:0], 2), $past(ee_data[15:8], 2)};
  endproperty
  a_latency_load: assert property (p_latency_load) else $error("Latency bytes not from EEPROM.");

  property p_ro_write;
    @(posedge clk) disable iff (!reset_n)
      do_write && !ee_valid && cfg_req.dword != CFGH_DW_MEM_BASE
      |=> $stable(bus_access_interval_ff) && $stable(burst_length_need_ff) && $stable(board_variant_code_ff);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("Read-only value changed by write.");

  // Writes answer with zero data, so a stale read word never rides on a write ack.
  property p_write_rdata_zero;
    @(posedge clk) disable iff (!reset_n)
      do_write |=> cfg_rsp.ack && cfg_rsp.rdata == 32'h00000000;
  endproperty
  a_write_rdata_zero: assert property (p_write_rdata_zero) else $error("Write answered with data.");

  property p_flag_load;
    @(posedge clk) disable iff (!reset_n)
      ee_valid && ee_addr == CFGH_EE_CONFIG_WORD
      |=> low_megabyte_flag_ff == $past(ee_data[CFGH_EE_LOW_MEG_BIT]);
  endproperty
  a_flag_load: assert property (p_flag_load) else $error("Low megabyte flag not loaded.");

  // The latency bytes may only move on a word from the EEPROM reader.
  property p_latency_hold;
    @(posedge clk) disable iff (!reset_n)
      !ee_valid |=> $stable(bus_access_interval_ff) && $stable(burst_length_need_ff);
  endproperty
  a_latency_hold: assert property (p_latency_hold) else $error("Latency byte moved without a load.");

  // Reset brings both latency bytes to the figure that the bus budget expects.
  property p_latency_reset;
    @(posedge clk)
      !reset_n |=> bus_access_interval_ff == CFGH_RST_ACCESS_INTERVAL
      && burst_length_need_ff == CFGH_RST_BURST_NEED;
  endproperty
  a_latency_reset: assert property (p_latency_reset) else $error("Latency bytes wrong after reset.");

  // A write without the top byte lane must leave the top base byte alone.
  property p_lane_hold;
    @(posedge clk) disable iff (!reset_n)
      do_write && cfg_req.dword == CFGH_DW_MEM_BASE && !cfg_req.byte_en[3]
      |=> window_base_ff[24:17] == $past(window_base_ff[24:17]);
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("Unenabled byte lane written.");
endmodule

/* File: testbench/cfgh_eeprom_model.sv */
// Model of the EEPROM reader that hands fetched words to the register block.
`timescale 1ns/1ps
module cfgh_eeprom_model (
  input wire logic clk, // Bench clock.
  input wire logic load, // Fetch request from the bench.
  input wire logic [5:0] addr, // Word address to deliver.
  input wire logic [15:0] data, // Word contents to deliver.
  output logic ee_valid, // One-cycle word strobe.
  output logic [5:0] ee_addr, // Delivered word address.
  output logic [15:0] ee_data // Delivered word contents.
);
  initial begin
    ee_valid = 1'b0;
    ee_addr = 6'h00;
    ee_data = 16'h0000;
  end
  // Outside a strobe the lines flip every cycle, so stale words never look valid.
  always @(posedge clk) begin
    ee_valid <= load;
    ee_addr <= load ? addr : ~ee_addr;
    ee_data <= load ? data : ~ee_data;
  end
endmodule

/* File: testbench/pci_config_header_regs_bench.sv */
// Self-checking bench for the configuration header registers.
`timescale 1ns/1ps
module pci_config_header_regs_bench;
  import cfgh_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value.
  logic clk, reset_n, ld, ee_valid, flag;
  logic [5:0] ld_addr, ee_addr;
  logic [15:0] ld_data, ee_data, lat, var_id;
  logic [31:0] seed, base, got, r;
  cfgh_req_t cfg_req;
  cfgh_rsp_t cfg_rsp;
  int bad_count, n_tests, cyc;
  cfgh_regs #(.SILICON_REVISION_CODE(REV)) i_cfgh_regs (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data));
  cfgh_eeprom_model i_cfgh_eeprom_model (.clk(clk), .load(ld), .addr(ld_addr), .data(ld_data),
    .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_win();
    return {base[31:7], 4'h0, 1'b0, flag, 1'b1};
  endfunction
  function automatic logic [31:0] exp_lat();
    return {lat[7:0], lat[15:8], 16'h0};
  endfunction
  task automatic expect_reset;
    base = {CFGH_RST_MEM_BASE, 7'h00};
    flag = CFGH_RST_LOW_MEG;
    lat = {CFGH_RST_BURST_NEED, CFGH_RST_ACCESS_INTERVAL};
    var_id = CFGH_RST_BOARD_VARIANT;
  endtask
  task automatic print_verdict;
    $display("Counts: %0d mismatches in %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access; the answer is sampled in the single cycle that it stands.
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    @(posedge clk);
    cfg_req <= '{1'b1, wr, dw, be, wd};
    @(posedge clk);
    cfg_req.valid <= 1'b0;
    #1;
    check({31'h0, cfg_rsp.ack}, 32'h1);
    got = cfg_rsp.rdata;
    if (wr) check(got, 32'h0);
  endtask
  // Write then read the window in back-to-back cycles; the read must see the new base.
  task automatic b2b_win(input logic [31:0] wd);
    @(posedge clk);
    cfg_req <= '{1'b1, 1'b1, CFGH_DW_MEM_BASE, 4'hF, wd};
    @(posedge clk);
    cfg_req <= '{1'b1, 1'b0, CFGH_DW_MEM_BASE, 4'hF, 32'h0};
    #1;
    check({31'h0, cfg_rsp.ack}, 32'h1);
    check(cfg_rsp.rdata, 32'h0);
    base[31:7] = wd[31:7];
    @(posedge clk);
    cfg_req.valid <= 1'b0;
    #1;
    check({31'h0, cfg_rsp.ack}, 32'h1);
    check(cfg_rsp.rdata, exp_win());
  endtask
  task automatic eload(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    ld <= 1'b1;
    ld_addr <= a;
    ld_data <= d;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic wr_win(input logic [3:0] be, input logic [31:0] wd);
    access(1'b1, CFGH_DW_MEM_BASE, be, wd);
    for (int k = 1; k < 4; k++) begin
      if (be[k]) base[8*k+:8] = wd[8*k+:8];
    end
    if (be[0]) base[7] = wd[7];
  endtask
  task automatic check_all;
    access(1'b0, CFGH_DW_REVISION, 4'hF, 32'h0);
    check(got, {24'h0, REV});
    access(1'b0, CFGH_DW_MEM_BASE, 4'hF, 32'h0);
    check(got, exp_win());
    access(1'b0, CFGH_DW_BOARD_VARIANT, 4'hF, 32'h0);
    check(got, {var_id, 16'h0});
    access(1'b0, CFGH_DW_LATENCY, 4'hF, 32'h0);
    check(got, exp_lat());
    access(1'b0, 6'h00, 4'hF, 32'h0);
    check(got, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    logic [5:0] ro [3];
    ro = '{CFGH_DW_REVISION, CFGH_DW_BOARD_VARIANT, CFGH_DW_LATENCY};
    reset_n = 1'b0;
    ld = 1'b0;
    ld_addr = 6'h00;
    ld_data = 16'h0000;
    cfg_req = '0;
    seed = 32'h25B9;
    expect_reset();
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    check_all();
    wr_win(4'hF, 32'hFFFFFFFF);
    check_all();
    b2b_win(xs());
    for (int i = 0; i < 40; i++) begin
      r = xs();
      case (r[1:0])
        2'd0: begin
          eload(CFGH_EE_LATENCY_WORD, r[23:8]);
          lat = r[23:8];
          access(1'b0, CFGH_DW_LATENCY, 4'hF, 32'h0);
          check(got, exp_lat());
        end
        2'd1: begin
          eload(CFGH_EE_CONFIG_WORD, r[23:8]);
          flag = r[8];
        end
        2'd2: begin
          eload(CFGH_EE_BOARD_VARIANT_WORD, r[23:8]);
          var_id = r[23:8];
        end
        default: begin
          wr_win(r[7:4], xs());
        end
      endcase
      access(1'b1, ro[i % 3], 4'hF, xs());
      if (r[24]) b2b_win(xs());
      check_all();
    end
    // A second reset in mid-run must bring back every value of the reset state.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    expect_reset();
    check_all();
    print_verdict();
  end
endmodule
